// ===== acdc_top.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Clock divider chain: source select, input, modulator, data rate
// ----------------------------------------------------------------------
module acdc_top (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       crystal_or_external_clock_pin,
  input  wire logic       sclk_pin_in,
  input  wire logic       sync_master_mode,
  output logic            sclk_pin_out,
  output logic            sclk_pin_oe,
  output logic            internal_clock_tick,
  output logic            modulator_clock_tick,
  output logic            data_rate_tick
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] src_div;   // Source select and input divider
    logic [7:0] mod_osr;   // Modulator divider and oversampling
    logic [7:0] rdata;     // Read data, valid one cycle after strobe
    logic       xtal_prev; // Crystal pin, previous sample
    logic       sclk_prev; // Serial clock pin, previous sample
  } acdc_st_t;

  localparam acdc_st_t ST_RESET = '{
    src_div:   acdc_pkg::RST_SRC_DIV,
    mod_osr:   acdc_pkg::RST_MOD_OSR,
    rdata:     8'h00,
    xtal_prev: 1'b0,
    sclk_prev: 1'b0
  };

  acdc_st_t st_reg;  // Registered state
  acdc_st_t st_next; // Next state

  // Decoded fields
  logic                            src_sel;  // 1 = serial clock pin
  logic [acdc_pkg::DIV_W-1:0]      idiv;     // Input divider code
  logic [acdc_pkg::DIV_W-1:0]      mdiv;     // Modulator divider code
  logic [acdc_pkg::OSR_W-1:0]      osr;      // Oversampling code
  logic                            src_tick; // Rising edge of source
  logic                            wr_src;   // Write to first register
  logic                            wr_mod;   // Write to second register
  logic                            rst_int;  // Restart internal stage
  logic                            rst_mod;  // Restart modulator stage
  logic                            rst_rate; // Restart data rate stage

  // Divider stage links
  acdc_div_if int_if ();
  acdc_div_if mod_if ();
  acdc_div_if rate_if ();

  assign src_sel = st_reg.src_div[acdc_pkg::SRC_BIT];
  assign idiv = st_reg.src_div[acdc_pkg::IDIV_LSB +: acdc_pkg::DIV_W];
  assign mdiv = st_reg.mod_osr[acdc_pkg::MDIV_LSB +: acdc_pkg::DIV_W];
  assign osr = st_reg.mod_osr[acdc_pkg::OSR_LSB +: acdc_pkg::OSR_W];

  // ----------------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------------
  // Pins are sampled levels; a rising edge is one source tick. The
  // source must stay below half of clk for no edge to be missed.
  always_comb begin
    if (src_sel) begin
      src_tick = sclk_pin_in & ~st_reg.sclk_prev;
    end else begin
      src_tick = crystal_or_external_clock_pin & ~st_reg.xtal_prev;
    end
  end

  // ----------------------------------------------------------------------
  // Register access and restart decisions
  // ----------------------------------------------------------------------
  assign wr_src = reg_wr && (reg_addr == acdc_pkg::OFF_SRC_DIV);
  assign wr_mod = reg_wr && (reg_addr == acdc_pkg::OFF_MOD_OSR);

  // Any change upstream restarts every stage below it
  assign rst_int = wr_src &&
    ((reg_wdata & acdc_pkg::MASK_SRC_DIV) != st_reg.src_div);
  assign rst_mod = rst_int || (wr_mod &&
    (reg_wdata[acdc_pkg::MDIV_LSB +: acdc_pkg::DIV_W] != mdiv));
  assign rst_rate = rst_mod || (wr_mod &&
    (reg_wdata[acdc_pkg::OSR_LSB +: acdc_pkg::OSR_W] != osr));

  // Next state of registers, read path and pin history
  always_comb begin
    st_next = st_reg;
    st_next.xtal_prev = crystal_or_external_clock_pin;
    st_next.sclk_prev = sclk_pin_in;
    // Reserved bits are not stored, so a careless host cannot
    // steer anything through them
    if (wr_src) begin
      st_next.src_div = reg_wdata & acdc_pkg::MASK_SRC_DIV;
    end
    if (wr_mod) begin
      st_next.mod_osr = reg_wdata & acdc_pkg::MASK_MOD_OSR;
    end
    // Read data stands only in the cycle after the strobe
    st_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        acdc_pkg::OFF_SRC_DIV: begin
          st_next.rdata = st_reg.src_div;
        end
        acdc_pkg::OFF_MOD_OSR: begin
          st_next.rdata = st_reg.mod_osr;
        end
        default: begin
          st_next.rdata = 8'h00; // Unmapped reads return zero
        end
      endcase
    end
  end

  // State register, synchronous reset to documented values
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------------
  // Input and modulator ratios are twice the code; reserved code 000 is clamped in the stage
  assign int_if.en = src_tick;
  assign int_if.restart = rst_int;
  assign int_if.ratio = {9'h000, idiv, 1'b0};

  assign mod_if.en = int_if.tick;
  assign mod_if.restart = rst_mod;
  assign mod_if.ratio = {9'h000, mdiv, 1'b0};

  assign rate_if.en = mod_if.tick;
  assign rate_if.restart = rst_rate;
  assign rate_if.ratio = acdc_pkg::OSR_TABLE[osr];

  acdc_div u_int_div (
    .clk    (clk),
    .resetn (resetn),
    .dv     (int_if)
  );

  acdc_div u_mod_div (
    .clk    (clk),
    .resetn (resetn),
    .dv     (mod_if)
  );

  acdc_div u_rate_div (
    .clk    (clk),
    .resetn (resetn),
    .dv     (rate_if)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = st_reg.rdata;
  assign internal_clock_tick = int_if.tick;
  assign modulator_clock_tick = mod_if.tick;
  assign data_rate_tick = rate_if.tick;
  // Master mode drives the internal clock out as serial clock
  assign sclk_pin_out = sync_master_mode & int_if.lvl;
  assign sclk_pin_oe = sync_master_mode;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_rd_src;
    reg_rd && reg_addr == acdc_pkg::OFF_SRC_DIV && !reg_wr;
  endsequence

  sequence s_rd_mod;
    reg_rd && reg_addr == acdc_pkg::OFF_MOD_OSR && !reg_wr;
  endsequence

  chk_reset_values: assert property (
    $rose(resetn) |-> st_reg.src_div == 8'h08 && osr == 4'h6 &&
                      mdiv == 3'h4 && !src_sel)
    else $error("Clock registers not at reset values");
  chk_src_select: assert property (
    src_sel && sclk_pin_in && !st_reg.sclk_prev |-> int_if.en)
    else $error("Serial clock edge not used as source");
  chk_xtal_select: assert property (
    !src_sel && !crystal_or_external_clock_pin |-> !int_if.en)
    else $error("Source tick without a crystal edge");
  chk_input_ratio: assert property (
    wr_src |=> int_if.ratio == 13'($past(reg_wdata[3:1]) * 2))
    else $error("Input divider ratio not twice the code");
  chk_mod_ratio: assert property (
    wr_mod |=> mod_if.ratio == 13'($past(reg_wdata[7:5]) * 2))
    else $error("Modulator ratio not twice the code");
  chk_osr_map: assert property (
    wr_mod && reg_wdata[3:0] == 4'h6 |=> rate_if.ratio == 13'd400)
    else $error("Oversampling code 0110 not ratio 400");
  chk_master_out: assert property (
    sync_master_mode |-> sclk_pin_oe && sclk_pin_out == int_if.lvl)
    else $error("Internal clock not driven in master mode");
  // Data stands one cycle, then zero unless a new read came in between
  chk_read_src: assert property (
    s_rd_src |=> reg_rdata == $past(st_reg.src_div) ##1
                 (reg_rdata == 8'h00 || $past(reg_rd)))
    else $error("First register read data wrong");
  chk_chain_restart: assert property (
    rst_int |=> !modulator_clock_tick && !data_rate_tick)
    else $error("Source change did not restart the chain");

  // ----------------------------------------------------------------------
  // Further checks on the register port and the chain
  // ----------------------------------------------------------------------
  // Second register read back one cycle after its strobe; software
  // relies on this to confirm a new rate before starting conversions
  chk_read_mod: assert property (
    s_rd_mod |=> reg_rdata == $past(st_reg.mod_osr))
    else $error("Second register read data wrong");

  // Without a strobe the read bus returns to zero, so a stale value
  // can never be mistaken for a fresh answer
  chk_read_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data stood longer than one cycle");

  // Unmapped reads answer zero rather than aliasing a register
  chk_read_unmapped: assert property (
    reg_rd && reg_addr != acdc_pkg::OFF_SRC_DIV &&
    reg_addr != acdc_pkg::OFF_MOD_OSR |=> reg_rdata == 8'h00)
    else $error("Unmapped read returned data");

  // Unmapped writes must leave both clock registers alone, since a
  // stray write would otherwise restart the whole chain
  chk_wr_unmapped: assert property (
    reg_wr && !wr_src && !wr_mod |=>
    $stable(st_reg.src_div) && $stable(st_reg.mod_osr))
    else $error("Unmapped write changed a clock register");

  // Reserved bits are never stored in the first register; a careless
  // host write must not reach the source or divider logic
  chk_reserved_src: assert property (
    (st_reg.src_div & ~acdc_pkg::MASK_SRC_DIV) == 8'h00)
    else $error("Reserved bit stored in first register");

  // Same for bit 4 of the second register
  chk_reserved_mod: assert property (
    (st_reg.mod_osr & ~acdc_pkg::MASK_MOD_OSR) == 8'h00)
    else $error("Reserved bit stored in second register");

  // Source select follows the written bit from the next cycle on
  chk_src_write: assert property (
    wr_src |=> src_sel == $past(reg_wdata[acdc_pkg::SRC_BIT]))
    else $error("Source select write did not land");

  // Oversampling code follows the written field
  chk_osr_write: assert property (
    wr_mod |=> osr == $past(reg_wdata[3:0]))
    else $error("Oversampling write did not land");

  // Outside master mode the serial clock pin is released and low,
  // so the host keeps sole ownership of the line
  chk_slave_release: assert property (
    !sync_master_mode |-> !sclk_pin_oe && !sclk_pin_out)
    else $error("Serial clock driven outside master mode");

  // Each stage after the input stage counts only ticks of the stage above it
  chk_mod_after_int: assert property (
    modulator_clock_tick |-> $past(internal_clock_tick))
    else $error("Modulator tick without an internal tick");

  // The data rate tick only follows a modulator tick
  chk_rate_after_mod: assert property (
    data_rate_tick |-> $past(modulator_clock_tick))
    else $error("Data rate tick without a modulator tick");

  // Ratio is at least two source edges, so ticks never touch
  chk_int_single: assert property (
    internal_clock_tick |=> !internal_clock_tick)
    else $error("Internal tick lasted two cycles");

endmodule // acdc_top
`default_nettype wire

// ===== acdc_pkg.sv
// ----------------------------------------------------------------------
// Clock divider chain constants
// ----------------------------------------------------------------------
package acdc_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [7:0] OFF_SRC_DIV = 8'h0d; // Source and input divider
  localparam logic [7:0] OFF_MOD_OSR = 8'h0e; // Modulator div and OSR

  // Reset values of the two registers
  localparam logic [7:0] RST_SRC_DIV = 8'h08;
  localparam logic [7:0] RST_MOD_OSR = 8'h86;

  // Writable bits; reserved bits are dropped and read back as zero
  localparam logic [7:0] MASK_SRC_DIV = 8'h8e;
  localparam logic [7:0] MASK_MOD_OSR = 8'hef;

  // Field positions and widths
  localparam int SRC_BIT = 7;  // Clock source select bit
  localparam int IDIV_LSB = 1; // Input divider field
  localparam int MDIV_LSB = 5; // Modulator divider field
  localparam int OSR_LSB = 0;  // Oversampling field
  localparam int DIV_W = 3;
  localparam int OSR_W = 4;

  // Counter widths: largest ratio is 4096
  localparam int CNT_W = 12;
  localparam int RATIO_W = 13;
  localparam logic [RATIO_W-1:0] RATIO_MIN = 13'h0002;

  // Oversampling ratio per code, code 0 first
  localparam logic [RATIO_W-1:0] OSR_TABLE [16] = '{
    13'h1000, 13'h0800, 13'h0400, 13'h0320,
    13'h0300, 13'h0200, 13'h0190, 13'h0180,
    13'h0100, 13'h00c8, 13'h00c0, 13'h0080,
    13'h0060, 13'h0040, 13'h0030, 13'h0020
  };

endpackage

// ===== acdc_div_if.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Link between the chain controller and one divider stage
// ----------------------------------------------------------------------
interface acdc_div_if;
  logic                              en;      // One input tick
  logic                              restart; // Clear the stage
  logic [acdc_pkg::RATIO_W-1:0]      ratio;   // Division ratio
  logic                              tick;    // One output tick
  logic                              lvl;     // Square output level

  modport div (input en, input restart, input ratio,
               output tick, output lvl);
  modport ctl (output en, output restart, output ratio,
               input tick, input lvl);
endinterface
`default_nettype wire

// ===== acdc_div.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// One divider stage: counts input ticks, emits a tick per ratio
// ----------------------------------------------------------------------
module acdc_div (
  input  wire logic clk,
  input  wire logic resetn,
  acdc_div_if.div   dv
);

  // Stage state
  typedef struct packed {
    logic [acdc_pkg::CNT_W-1:0] cnt; // Input ticks seen this period
    logic                       tick; // Output tick
    logic                       lvl;  // High during first half period
  } acdc_div_st_t;

  localparam acdc_div_st_t ST_RESET = '{cnt: '0, tick: 1'b0, lvl: 1'b1};

  acdc_div_st_t                 st_reg;    // Registered state
  acdc_div_st_t                 st_next;   // Next state
  logic [acdc_pkg::RATIO_W-1:0] ratio_eff; // Ratio, never below two
  logic                         wrap;      // Last tick of a period

  // Reserved code 000 gives ratio 0; clamp so the stage never stalls
  assign ratio_eff = (dv.ratio < acdc_pkg::RATIO_MIN) ?
                     acdc_pkg::RATIO_MIN : dv.ratio;
  assign wrap = ({1'b0, st_reg.cnt} == (ratio_eff - 13'h0001));

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (dv.restart) begin
      // Setting changed: restart from the top of a period
      st_next.cnt = '0;
    end else if (dv.en) begin
      if (wrap) begin
        st_next.cnt = '0;
        st_next.tick = 1'b1; // Enable pulse, not a derived clock
      end else begin
        st_next.cnt = st_reg.cnt + 12'h001;
      end
    end
    // Even ratios give an exact 50 percent duty output
    st_next.lvl = ({1'b0, st_next.cnt} < (ratio_eff >> 1));
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dv.tick = st_reg.tick;
  assign dv.lvl = st_reg.lvl;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_tick_on_wrap: assert property (
    dv.en && wrap && !dv.restart |=> dv.tick && st_reg.cnt == '0)
    else $error("Stage missed its period tick");
  chk_restart_clear: assert property (
    dv.restart |=> st_reg.cnt == '0 && !dv.tick)
    else $error("Restart did not clear the stage");
  chk_count_hold: assert property (
    !dv.en && !dv.restart |=> $stable(st_reg.cnt) && !dv.tick)
    else $error("Stage moved without an input tick");

endmodule // acdc_div
`default_nettype wire

// ===== acdc_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Far side: crystal oscillator and the serial clock of the host
// ----------------------------------------------------------------------
module acdc_src_model (
  input  wire logic       clk,
  input  wire logic       run_xtal, // Oscillator running
  input  wire logic       run_sclk, // Host clocking a frame
  input  wire logic [3:0] half,     // Half period in clk cycles
  output logic            xtal_out, // Crystal or clock-input level
  output logic            sclk_out  // Serial clock level
);
  logic [3:0] cnt_reg; // Half-period counter

  // Defined levels from time zero
  initial begin
    cnt_reg  = 4'h0;
    xtal_out = 1'b0;
    sclk_out = 1'b0;
  end

  // Both sources share one half period; keep half at 2 or more so the
  // source never toggles as fast as clk/2, which the block cannot see
  always @(posedge clk) begin
    if (cnt_reg >= half - 4'h1) begin
      cnt_reg <= 4'h0;
      if (run_xtal) begin
        xtal_out <= ~xtal_out;
      end
      // Serial clock idles low between frames, it never runs free
      sclk_out <= run_sclk ? ~sclk_out : 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule // acdc_src_model
`default_nettype wire

// ===== acdc_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Self-checking bench for the clock divider chain
// ----------------------------------------------------------------------
module acdc_top_tb_top;
  logic       clk, resetn, reg_wr, reg_rd, mode, run_xtal, run_sclk;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       xtal, sclk, sclk_out, sclk_oe, i_tick, m_tick, d_tick;
  logic [3:0] half;
  int         fail_count, n_compared;
  // Expected oversampling ratio per code, code 0 first
  int ratio [16] = '{4096, 2048, 1024, 800, 768, 512, 400, 384,
                     256, 200, 192, 128, 96, 64, 48, 32};

  // Clock of 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  acdc_src_model acdc_src_model_inst (.clk(clk), .run_xtal(run_xtal),
    .run_sclk(run_sclk), .half(half), .xtal_out(xtal), .sclk_out(sclk));

  acdc_top acdc_top_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .crystal_or_external_clock_pin(xtal),
    .sclk_pin_in(sclk), .sync_master_mode(mode), .sclk_pin_out(sclk_out),
    .sclk_pin_oe(sclk_oe), .internal_clock_tick(i_tick),
    .modulator_clock_tick(m_tick), .data_rate_tick(d_tick));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts and verdict
  task automatic end_sim;
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read strobe; data is taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function automatic logic pick(input int sel);
    return sel == 0 ? i_tick : (sel == 1 ? m_tick : d_tick);
  endfunction

  // Third tick interval: the first after a restart may be stale
  task automatic measure(input int sel, output int cyc, output int mods,
                         output int hi);
    int n;
    cyc  = 0;
    mods = 0;
    hi   = 0;
    for (int i = 0; i < 3; i++) begin
      n = 0;
      do begin
        @(posedge clk);
        #1 n++;
        if (i == 2) begin
          cyc++;
          mods += int'(m_tick === 1'b1);
          hi   += int'(sclk_out === 1'b1);
        end
      end while (pick(sel) !== 1'b1 && n < 20000);
      if (n >= 20000) begin
        fail_count++;
        $display("CHECK FAILED at %0t: tick wait ran out", $time);
        end_sim();
      end
    end
  endtask

  // Internal ticks seen over a window
  task automatic count_ticks(output int t);
    t = 0;
    repeat (4) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      #1 t += int'(i_tick === 1'b1);
    end
  endtask

  task automatic t_reset;
    logic [7:0] d;
    rd(8'h0d, d);
    check(d, 8'h08);
    @(posedge clk);
    #1 check(reg_rdata, 8'h00);
    rd(8'h0e, d);
    check(d, 8'h86);
    wr(8'h0f, 8'hff);
    rd(8'h0f, d);
    check(d, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {3'(i % 7 + 1), 1'b0, 4'(i)};
      wr(8'h0e, v);
      rd(8'h0e, d);
      check(d, v);
    end
    rd(8'h0d, d);
    check(d, 8'h08);
    $display("register test done");
  endtask

  task automatic t_idiv;
    int c, m, h;
    wr(8'h0e, 8'h86);
    for (int k = 1; k < 8; k++) begin
      wr(8'h0d, {4'h0, 3'(k), 1'b0});
      measure(0, c, m, h);
      check(c, 8 * k);
    end
    $display("input divider test done");
  endtask

  task automatic t_mdiv;
    int c, m, h;
    wr(8'h0d, 8'h02);
    for (int k = 1; k < 8; k++) begin
      wr(8'h0e, {3'(k), 1'b0, 4'h6});
      measure(1, c, m, h);
      check(c, 16 * k);
    end
    $display("modulator divider test done");
  endtask

  task automatic t_osr;
    int c, m, h;
    for (int k = 6; k < 16; k++) begin
      wr(8'h0e, {3'h1, 1'b0, 4'(k)});
      measure(2, c, m, h);
      check(m, ratio[k]);
    end
    $display("oversampling test done");
  endtask

  task automatic t_src;
    int c, m, h, t;
    wr(8'h0d, 8'h82);
    count_ticks(t);
    check(t, 0);
    @(posedge clk);
    run_sclk <= 1'b1;
    measure(0, c, m, h);
    check(c, 8);
    @(posedge clk);
    mode <= 1'b1;
    measure(0, c, m, h);
    check(h, 4);
    check(sclk_oe, 1'b1);
    @(posedge clk);
    mode     <= 1'b0;
    run_xtal <= 1'b0;
    wr(8'h0d, 8'h02);
    count_ticks(t);
    check(t, 0);
    check({sclk_oe, sclk_out}, 2'b00);
    $display("source select test done");
  endtask

  // Main sequence
  initial begin
    resetn     = 1'b0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    mode       = 1'b0;
    run_xtal   = 1'b1;
    run_sclk   = 1'b0;
    half       = 4'h2;
    fail_count = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_idiv();
    t_mdiv();
    t_osr();
    t_src();
    end_sim();
  end
endmodule // acdc_top_tb_top
`default_nettype wire
